// [cdec_defs.svh]
// Purpose: Shared constants for the compact instruction decoder.
// Assumes: Expanded instructions always carry the always-execute condition.
// Notes: Opcode values are the full-width data processing opcodes.
`ifndef CDEC_DEFS_SVH
`define CDEC_DEFS_SVH
`define CDEC_COND_AL 4'hE
`define CDEC_OPC_AND 4'h0
`define CDEC_OPC_EOR 4'h1
`define CDEC_OPC_SUB 4'h2
`define CDEC_OPC_RSB 4'h3
`define CDEC_OPC_ADD 4'h4
`define CDEC_OPC_ADC 4'h5
`define CDEC_OPC_SBC 4'h6
`define CDEC_OPC_TST 4'h8
`define CDEC_OPC_CMP 4'hA
`define CDEC_OPC_CMN 4'hB
`define CDEC_OPC_MOV 4'hD
`define CDEC_SH_LSL 2'h0
`define CDEC_SH_LSR 2'h1
`define CDEC_SH_ASR 2'h2
`define CDEC_SH_ROR 2'h3
`define CDEC_MUL_TAG 4'h9
`define CDEC_BX_STEM 24'h12_FFF1
`define CDEC_NULL_INSTR 32'h0000_0000
`endif

// [cdec_pkg.sv]
// Purpose: Types shared by the compact instruction decoder modules.
// Assumes: Nothing beyond the constants header.
// Notes: Format codes follow a Gray sequence in format order; only the undefined code 5'h1E breaks it.
package cdec_pkg;
  typedef enum logic [4:0] {
    CDEC_F_SHIFT = 5'h00, CDEC_F_ADDSUB = 5'h01, CDEC_F_IMM = 5'h03,
    CDEC_F_ALU = 5'h02, CDEC_F_HIREG = 5'h06, CDEC_F_PCLOAD = 5'h07,
    CDEC_F_LSREG = 5'h05, CDEC_F_LSSIGN = 5'h04, CDEC_F_LSIMM = 5'h0C,
    CDEC_F_LSHALF = 5'h0D, CDEC_F_SPLS = 5'h0F, CDEC_F_LDADDR = 5'h0E,
    CDEC_F_SPADJ = 5'h0A, CDEC_F_PUSHPOP = 5'h0B, CDEC_F_MULTI = 5'h09,
    CDEC_F_CONDBR = 5'h08, CDEC_F_TRAP = 5'h18, CDEC_F_BRANCH = 5'h19,
    CDEC_F_LONGBL = 5'h1B, CDEC_F_UNDEF = 5'h1E
  } cdec_fmt_e;
  typedef logic [15:0] cdec_half_t;
  typedef logic [31:0] cdec_word_t;
endpackage

// [cdec_fmt_if.sv]
// Purpose: Carries an instruction to the format classifier and its verdict back.
// Assumes: Purely combinational traffic within one clock domain.
// Notes: None.
`timescale 1ns/1ps
interface cdec_fmt_if;
  import cdec_pkg::*;
  cdec_half_t instr;
  cdec_fmt_e fmt;
  modport req (output instr, input fmt);
  modport cls (input instr, output fmt);
endinterface

// [cdec_fmt_classify.sv]
// Purpose: Recognises the format of a compact instruction from its top bits.
// Assumes: The instruction is stable for the cycle in which it is classified.
// Notes: Anything matching no format is reported as undefined.
`timescale 1ns/1ps
module cdec_fmt_classify
  import cdec_pkg::*;
(
  // Classification request and verdict
  cdec_fmt_if.cls fi
);
  wire [15:0] i = fi.instr;
  wire shift_op_ok = i[12:11] != 2'b11;
  wire spadj_ok = i[11:8] == 4'h0;
  wire push_ok = i[10:9] == 2'b10;
  wire trap_cond = i[11:8] == 4'hF;

  always_comb begin
    fi.fmt = CDEC_F_UNDEF;
    case (i[15:13])
      3'b000: begin
        if (shift_op_ok) begin
          fi.fmt = CDEC_F_SHIFT;
        end else begin
          fi.fmt = CDEC_F_ADDSUB;
        end
      end
      3'b001: fi.fmt = CDEC_F_IMM;
      3'b010: begin
        if (i[12]) begin
          fi.fmt = i[9] ? CDEC_F_LSSIGN : CDEC_F_LSREG;
        end else if (i[11]) begin
          fi.fmt = CDEC_F_PCLOAD;
        end else begin
          fi.fmt = i[10] ? CDEC_F_HIREG : CDEC_F_ALU;
        end
      end
      3'b011: fi.fmt = CDEC_F_LSIMM;
      3'b100: fi.fmt = i[12] ? CDEC_F_SPLS : CDEC_F_LSHALF;
      3'b101: begin
        if (!i[12]) begin
          fi.fmt = CDEC_F_LDADDR;
        end else if (spadj_ok) begin
          fi.fmt = CDEC_F_SPADJ;
        end else if (push_ok) begin
          fi.fmt = CDEC_F_PUSHPOP;
        end
      end
      3'b110: begin
        if (!i[12]) begin
          fi.fmt = CDEC_F_MULTI;
        end else begin
          fi.fmt = trap_cond ? CDEC_F_TRAP : CDEC_F_CONDBR;
        end
      end
      3'b111: begin
        if (i[12]) begin
          fi.fmt = CDEC_F_LONGBL;
        end else if (!i[11]) begin
          fi.fmt = CDEC_F_BRANCH;
        end
      end
      default: fi.fmt = CDEC_F_UNDEF;
    endcase
  end
endmodule

// [cdec_top.sv]
// Purpose: Expands compact 16-bit instructions into full-width equivalents.
// Assumes: One instruction may arrive every cycle; the datapath takes one per cycle.
// Notes: Formats outside the arithmetic and high-register groups are classified but emit a null word.
// Function
// - Expand every arithmetic and high-register instruction into its full-width equivalent before execution.
// - Shift-immediate codes 00/01/10 select left, right or arithmetic right shift.
// - Shift, add/subtract, immediate and register-pair groups all update flags.
// - Add/subtract picks register or 3-bit immediate, and add or subtract.
// - Immediate group does move, compare, add, subtract with 8-bit immediate.
// - Compare with immediate only sets flags; register unchanged.
// - Pair codes add with carry and subtract with borrow.
// - Pair test, compare and compare-by-sum only set flags.
// - Expansion adds no execution cycles.
// - High-register add and move leave flags unchanged.
// - High-register group decodes add, compare, move and state-switch branch.
// - Add, compare, move and branch all reach high registers.
// - Recognise load/store, stack, push/pop, multiple, branch and trap formats.
// - Long branch with link is its own format.
// - Recognise stack pointer offset adjust format.
// - High group: only compare sets flags; add, compare or move with both high bits clear undefined.
// - Target bit 0 selects the new instruction-set state.
`timescale 1ns/1ps
`include "cdec_defs.svh"
module cdec_top
  import cdec_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Fetch side
  input wire logic in_valid,
  input wire logic [15:0] in_instr,
  // Execution side
  output logic out_valid,
  output logic [31:0] out_instr,
  output cdec_fmt_e out_fmt,
  output logic out_flags_upd,
  output logic out_dest_wr,
  output logic [3:0] out_dest,
  output logic out_undef,
  output logic out_state_switch
);
  function automatic logic [31:0] dp(input logic [3:0] opc, input logic imm,
                                     input logic s, input logic [3:0] rn,
                                     input logic [3:0] rd, input logic [11:0] op2);
    dp = {`CDEC_COND_AL, 2'b00, imm, opc, s, rn, rd, op2};
  endfunction

  function automatic logic [3:0] lo(input logic [2:0] r);
    lo = {1'b0, r};
  endfunction

  cdec_fmt_if fi ();
  assign fi.instr = in_instr;
  cdec_fmt_classify u_cls (
    .fi(fi)
  );

  wire [2:0] r0 = in_instr[2:0];
  wire [2:0] r3 = in_instr[5:3];
  wire [2:0] r6 = in_instr[8:6];
  wire [2:0] r8 = in_instr[10:8];
  wire [4:0] shift_imm5 = in_instr[10:6];
  wire [1:0] function_code = in_instr[12:11];
  wire imm_sel = in_instr[10];
  wire sub_sel = in_instr[9];
  wire [7:0] byte_imm = in_instr[7:0];
  wire [3:0] alu_code = in_instr[9:6];
  wire [1:0] hi_op = in_instr[9:8];
  wire hi_dest_flag = in_instr[7];
  wire hi_src_flag = in_instr[6];
  wire [3:0] hi_dest = {hi_dest_flag, r0};
  wire [3:0] hi_src = {hi_src_flag, r3};
  wire [3:0] lo_d = lo(r0);
  wire [3:0] lo_s = lo(r3);
  wire hi_none = !hi_dest_flag && !hi_src_flag;
  wire alu_is_shift = alu_code == 4'h2 || alu_code == 4'h3 ||
                      alu_code == 4'h4 || alu_code == 4'h7;
  wire alu_flag_only = alu_code == 4'h8 || alu_code == 4'hA || alu_code == 4'hB;
  wire [1:0] alu_sh = (alu_code == 4'h2) ? `CDEC_SH_LSL :
                      (alu_code == 4'h3) ? `CDEC_SH_LSR :
                      (alu_code == 4'h4) ? `CDEC_SH_ASR : `CDEC_SH_ROR;
  wire [11:0] alu_rs_op2 = {8'h00, lo_s};
  wire [11:0] hi_rs_op2 = {8'h00, hi_src};

  logic [31:0] instr_next;
  logic flags_next;
  logic wr_next;
  logic [3:0] dest_next;
  logic undef_next;
  logic switch_next;

  always_comb begin
    instr_next = `CDEC_NULL_INSTR;
    flags_next = 1'b0;
    wr_next = 1'b0;
    dest_next = 4'h0;
    undef_next = 1'b0;
    switch_next = 1'b0;
    case (fi.fmt)
      CDEC_F_SHIFT: begin
        instr_next = dp(`CDEC_OPC_MOV, 1'b0, 1'b1, 4'h0, lo_d,
                        {shift_imm5, function_code, 1'b0, lo_s});
        flags_next = 1'b1;
        wr_next = 1'b1;
        dest_next = lo_d;
      end
      CDEC_F_ADDSUB: begin
        instr_next = dp(sub_sel ? `CDEC_OPC_SUB : `CDEC_OPC_ADD, imm_sel, 1'b1,
                        lo_s, lo_d, {9'h000, r6});
        flags_next = 1'b1;
        wr_next = 1'b1;
        dest_next = lo_d;
      end
      CDEC_F_IMM: begin
        flags_next = 1'b1;
        dest_next = lo(r8);
        wr_next = function_code != 2'b01;
        case (function_code)
          2'b00: instr_next = dp(`CDEC_OPC_MOV, 1'b1, 1'b1, 4'h0, lo(r8),
                                 {4'h0, byte_imm});
          2'b01: instr_next = dp(`CDEC_OPC_CMP, 1'b1, 1'b1, lo(r8), 4'h0,
                                 {4'h0, byte_imm});
          2'b10: instr_next = dp(`CDEC_OPC_ADD, 1'b1, 1'b1, lo(r8), lo(r8),
                                 {4'h0, byte_imm});
          default: instr_next = dp(`CDEC_OPC_SUB, 1'b1, 1'b1, lo(r8), lo(r8),
                                   {4'h0, byte_imm});
        endcase
      end
      CDEC_F_ALU: begin
        flags_next = 1'b1;
        dest_next = lo_d;
        wr_next = !alu_flag_only;
        if (alu_is_shift) begin
          instr_next = dp(`CDEC_OPC_MOV, 1'b0, 1'b1, 4'h0, lo_d,
                          {lo_s, 1'b0, alu_sh, 1'b1, lo_d});
        end else if (alu_flag_only) begin
          instr_next = dp(alu_code, 1'b0, 1'b1, lo_d, 4'h0, alu_rs_op2);
        end else if (alu_code == 4'h9) begin
          instr_next = dp(`CDEC_OPC_RSB, 1'b1, 1'b1, lo_s, lo_d, 12'h000);
        end else if (alu_code == 4'hD) begin
          instr_next = {`CDEC_COND_AL, 7'h00, 1'b1, lo_d, 4'h0, lo_d,
                        `CDEC_MUL_TAG, lo_s};
        end else if (alu_code == 4'hF) begin
          instr_next = dp(alu_code, 1'b0, 1'b1, 4'h0, lo_d, alu_rs_op2);
        end else begin
          // Remaining codes share their full-width opcode value, carry forms included.
          instr_next = dp(alu_code, 1'b0, 1'b1, lo_d, lo_d, alu_rs_op2);
        end
      end
      CDEC_F_HIREG: begin
        case (hi_op)
          2'b00: begin
            instr_next = dp(`CDEC_OPC_ADD, 1'b0, 1'b0, hi_dest, hi_dest,
                            hi_rs_op2);
            wr_next = 1'b1;
            dest_next = hi_dest;
            undef_next = hi_none;
          end
          2'b01: begin
            instr_next = dp(`CDEC_OPC_CMP, 1'b0, 1'b1, hi_dest, 4'h0,
                            hi_rs_op2);
            flags_next = 1'b1;
            undef_next = hi_none;
          end
          2'b10: begin
            instr_next = dp(`CDEC_OPC_MOV, 1'b0, 1'b0, 4'h0, hi_dest,
                            hi_rs_op2);
            wr_next = 1'b1;
            dest_next = hi_dest;
            undef_next = hi_none;
          end
          default: begin
            // The core picks the new state from bit 0 of the target register.
            instr_next = {`CDEC_COND_AL, `CDEC_BX_STEM, hi_src};
            switch_next = 1'b1;
            undef_next = hi_dest_flag;
          end
        endcase
      end
      CDEC_F_UNDEF: undef_next = 1'b1;
      default: undef_next = 1'b0;
    endcase
    if (undef_next) begin
      instr_next = `CDEC_NULL_INSTR;
      flags_next = 1'b0;
      wr_next = 1'b0;
      dest_next = 4'h0;
      switch_next = 1'b0;
    end
  end

  // One register stage, one instruction per cycle, matches the full-width decode slot.
  always_ff @(posedge clk) begin
    if (reset) begin
      out_valid <= 1'b0;
      out_instr <= `CDEC_NULL_INSTR;
      out_fmt <= CDEC_F_UNDEF;
      out_flags_upd <= 1'b0;
      out_dest_wr <= 1'b0;
      out_dest <= 4'h0;
      out_undef <= 1'b0;
      out_state_switch <= 1'b0;
    end else begin
      out_valid <= in_valid;
      out_instr <= in_valid ? instr_next : `CDEC_NULL_INSTR;
      out_fmt <= fi.fmt;
      out_flags_upd <= in_valid && flags_next;
      out_dest_wr <= in_valid && wr_next;
      out_dest <= dest_next;
      out_undef <= in_valid && undef_next;
      out_state_switch <= in_valid && switch_next;
    end
  end

  pipe_slot_a: assert property (@(posedge clk) disable iff (reset)
    in_valid |=> out_valid)
    else $error("Accepted instruction did not emerge next cycle.");

  arith_flags_a: assert property (@(posedge clk) disable iff (reset)
    out_valid && (out_fmt == CDEC_F_SHIFT || out_fmt == CDEC_F_ADDSUB ||
                  out_fmt == CDEC_F_IMM || out_fmt == CDEC_F_ALU) |-> out_flags_upd)
    else $error("Arithmetic group instruction lost its flag update.");

  shift_kind_a: assert property (@(posedge clk) disable iff (reset)
    in_valid && in_instr[15:13] == 3'b000 && in_instr[12:11] != 2'b11
    |=> out_instr[6:5] == $past(in_instr[12:11]) && out_instr[11:7] == $past(in_instr[10:6]))
    else $error("Shift type or amount not carried into the expansion.");

  split_route_a: assert property (@(posedge clk) disable iff (reset)
    in_valid && in_instr[15:11] == 5'b00011 |=> out_fmt == CDEC_F_ADDSUB)
    else $error("Function code 11 not routed to add/subtract.");

  cmp_imm_a: assert property (@(posedge clk) disable iff (reset)
    out_valid && out_fmt == CDEC_F_IMM && out_instr[24:21] == `CDEC_OPC_CMP
    |-> !out_dest_wr && out_flags_upd)
    else $error("Compare with immediate wrote its register.");

  flag_only_a: assert property (@(posedge clk) disable iff (reset)
    in_valid && in_instr[15:10] == 6'b010000 &&
    (in_instr[9:6] == 4'h8 || in_instr[9:6] == 4'hA || in_instr[9:6] == 4'hB)
    |=> !out_dest_wr && out_flags_upd)
    else $error("Flag-only pair operation wrote the destination.");

  hi_flags_a: assert property (@(posedge clk) disable iff (reset)
    out_valid && out_fmt == CDEC_F_HIREG && out_flags_upd
    |-> out_instr[24:21] == `CDEC_OPC_CMP)
    else $error("High-register operation other than compare set flags.");

  hi_undef_a: assert property (@(posedge clk) disable iff (reset)
    in_valid && in_instr[15:10] == 6'b010001 && in_instr[9:8] != 2'b11 &&
    in_instr[7:6] == 2'b00 |=> out_undef)
    else $error("High-register form with no high operand accepted.");

  undef_null_a: assert property (@(posedge clk) disable iff (reset)
    out_undef |-> out_instr == `CDEC_NULL_INSTR && !out_dest_wr && !out_flags_upd)
    else $error("Undefined encoding produced an executable word.");

  bx_target_a: assert property (@(posedge clk) disable iff (reset)
    out_state_switch |-> out_instr[31:4] == {`CDEC_COND_AL, `CDEC_BX_STEM})
    else $error("State-switch branch expansion malformed.");

  addsub_form_a: assert property (@(posedge clk) disable iff (reset)
    in_valid && in_instr[15:11] == 5'b00011
    |=> out_instr[25] == $past(in_instr[10]) && out_dest_wr && out_instr[24:21] ==
        ($past(in_instr[9]) ? `CDEC_OPC_SUB : `CDEC_OPC_ADD))
    else $error("Add or subtract operand choice not carried into the expansion.");

  imm_form_a: assert property (@(posedge clk) disable iff (reset)
    in_valid && in_instr[15:13] == 3'b001
    |=> out_instr[25] && out_instr[11:0] == {4'h0, $past(in_instr[7:0])} &&
        out_dest == {1'b0, $past(in_instr[10:8])})
    else $error("Immediate operand or register lost in the expansion.");

  pair_logic_a: assert property (@(posedge clk) disable iff (reset)
    in_valid && in_instr[15:10] == 6'b010000 &&
    (in_instr[9:6] inside {4'h0, 4'h1, 4'hC, 4'hE, 4'hF})
    |=> out_dest_wr && !out_instr[25] && out_instr[24:21] == $past(in_instr[9:6]))
    else $error("Pair logic operation expanded to the wrong opcode.");

  pair_shift_a: assert property (@(posedge clk) disable iff (reset)
    in_valid && in_instr[15:10] == 6'b010000 &&
    (in_instr[9:6] inside {4'h2, 4'h3, 4'h4, 4'h7})
    |=> out_instr[24:21] == `CDEC_OPC_MOV && out_instr[4] && out_dest_wr &&
        out_instr[11:8] == {1'b0, $past(in_instr[5:3])})
    else $error("Pair shift amount not taken from the source register.");

  pair_carry_a: assert property (@(posedge clk) disable iff (reset)
    in_valid && in_instr[15:10] == 6'b010000 && (in_instr[9:6] inside {4'h5, 4'h6})
    |=> out_dest_wr && out_instr[24:21] ==
        ($past(in_instr[6]) ? `CDEC_OPC_ADC : `CDEC_OPC_SBC))
    else $error("Carry form of a pair operation expanded wrongly.");

  pair_negate_a: assert property (@(posedge clk) disable iff (reset)
    in_valid && in_instr[15:10] == 6'b010000 && in_instr[9:6] == 4'h9
    |=> out_instr[25:21] == {1'b1, `CDEC_OPC_RSB} && out_instr[11:0] == 12'h000 &&
        out_dest_wr)
    else $error("Negate did not expand to a reverse subtract from zero.");

  pair_mul_a: assert property (@(posedge clk) disable iff (reset)
    in_valid && in_instr[15:10] == 6'b010000 && in_instr[9:6] == 4'hD
    |=> out_instr[7:4] == `CDEC_MUL_TAG && out_instr[20] && out_dest_wr &&
        out_instr[19:16] == {1'b0, $past(in_instr[2:0])})
    else $error("Multiply did not target the destination register.");

  hi_noflag_a: assert property (@(posedge clk) disable iff (reset)
    in_valid && in_instr[15:10] == 6'b010001 && !in_instr[8] && in_instr[7:6] != 2'b00
    |=> out_dest_wr && !out_flags_upd)
    else $error("High-register add or move touched the flags.");
endmodule

// [cdec_exec_model.sv]
// Purpose: Stands in for the execution datapath that consumes expanded words.
// Assumes: One decoded word per cycle and no back-pressure.
// Notes: Tallies words executed and words that take the undefined trap.
`timescale 1ns/1ps
module cdec_exec_model
  import cdec_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Decoded stream
  input wire logic dec_valid,
  input wire logic dec_undef,
  // Tallies
  output int n_exec,
  output int n_trap
);
  // An undefined word takes the trap and is never executed.
  always @(posedge clk) begin
    if (reset) begin
      n_exec <= 0;
      n_trap <= 0;
    end else if (dec_valid) begin
      if (dec_undef) begin
        n_trap <= n_trap + 1;
      end else begin
        n_exec <= n_exec + 1;
      end
    end
  end
endmodule

// [cdec_top_test.sv]
// Purpose: Self-checking bench for the compact instruction decoder.
// Assumes: Outputs follow each accepted instruction by exactly one cycle.
// Notes: Expected words are built from the full-width field layout.
`timescale 1ns/1ps
`include "cdec_defs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module cdec_top_test;
  import cdec_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic in_valid = 1'b1;
  logic [15:0] in_instr = 16'h1888;
  logic out_valid, out_flags_upd, out_dest_wr, out_undef, out_state_switch;
  logic [31:0] out_instr;
  logic [3:0] out_dest;
  cdec_fmt_e out_fmt;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int exp_exec = 0;
  int exp_trap = 0;
  int n_exec, n_trap;

  always #12.5 clk = ~clk;

  cdec_top dut (.clk(clk), .reset(reset), .in_valid(in_valid), .in_instr(in_instr),
    .out_valid(out_valid), .out_instr(out_instr), .out_fmt(out_fmt),
    .out_flags_upd(out_flags_upd), .out_dest_wr(out_dest_wr), .out_dest(out_dest),
    .out_undef(out_undef), .out_state_switch(out_state_switch));

  cdec_exec_model model (.clk(clk), .reset(reset), .dec_valid(out_valid),
    .dec_undef(out_undef), .n_exec(n_exec), .n_trap(n_trap));

  function automatic logic [31:0] dp(input logic i, input logic [3:0] opc, input logic s,
      input logic [3:0] rn, input logic [3:0] rd, input logic [11:0] op2);
    return {`CDEC_COND_AL, 2'b00, i, opc, s, rn, rd, op2};
  endfunction

  task automatic results;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // The whole run needs well under a hundred cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 500) begin
      n_errors++;
      results();
    end
  end

  // Flag bits are ordered flags update, dest write, undefined, state switch.
  task automatic xfer(input logic [15:0] ins, input logic [31:0] ei, input cdec_fmt_e ef,
      input logic [3:0] bits, input logic [3:0] dst, input bit cf);
    in_valid = 1'b1;
    in_instr = ins;
    @(posedge clk);
    #1;
    if (bits[1]) exp_trap++;
    else exp_exec++;
    `CHK(out_valid, 1'b1)
    `CHK(out_instr, ei)
    if (cf) `CHK(out_fmt, ef)
    `CHK({out_flags_upd, out_dest_wr, out_undef, out_state_switch}, bits)
    `CHK(out_dest, dst)
  endtask

  task automatic idle(input string name);
    in_valid = 1'b0;
    @(posedge clk);
    #1;
    `CHK({out_valid, out_instr, out_undef}, 34'h0_0000_0000)
    $display("test %s done", name);
  endtask

  task automatic test_shift;
    for (int op = 0; op < 3; op++) begin
      xfer({3'b000, 2'(op), 5'h1F, 3'd7, 3'd6}, dp(1'b0, `CDEC_OPC_MOV, 1'b1, 4'h0, 4'h6,
        {5'h1F, 2'(op), 1'b0, 4'h7}), CDEC_F_SHIFT, 4'b1100, 4'h6, 1'b1);
    end
    idle("shift");
  endtask

  task automatic test_addsub;
    for (int k = 0; k < 4; k++) begin
      xfer({5'b00011, 2'(k), 3'd5, 3'd3, 3'd4}, dp(k[1], k[0] ? `CDEC_OPC_SUB : `CDEC_OPC_ADD,
        1'b1, 4'h3, 4'h4, 12'h005), CDEC_F_ADDSUB, 4'b1100, 4'h4, 1'b1);
    end
    idle("addsub");
  endtask

  task automatic test_imm;
    logic [3:0] oc [4] = '{`CDEC_OPC_MOV, `CDEC_OPC_CMP, `CDEC_OPC_ADD, `CDEC_OPC_SUB};
    for (int k = 0; k < 4; k++) begin
      xfer({3'b001, 2'(k), 3'd3, 8'hA5}, dp(1'b1, oc[k], 1'b1, (k == 0) ? 4'h0 : 4'h3,
        (k == 1) ? 4'h0 : 4'h3, 12'h0A5), CDEC_F_IMM, {1'b1, k != 1, 2'b00},
        4'h3, 1'b1);
    end
    idle("imm");
  endtask

  task automatic test_alu;
    logic [31:0] e;
    logic [3:0] b;
    for (int k = 0; k < 16; k++) begin
      b = 4'b1100;
      case (k)
        2, 3, 4, 7: e = dp(1'b0, `CDEC_OPC_MOV, 1'b1, 4'h0, 4'h2,
          {4'h5, 1'b0, (k == 7) ? 2'd3 : 2'(k - 2), 1'b1, 4'h2});
        8, 10, 11: begin
          e = dp(1'b0, 4'(k), 1'b1, 4'h2, 4'h0, 12'h005);
          b = 4'b1000;
        end
        9: e = dp(1'b1, `CDEC_OPC_RSB, 1'b1, 4'h5, 4'h2, 12'h000);
        13: e = {`CDEC_COND_AL, 8'h01, 4'h2, 4'h0, 4'h2, `CDEC_MUL_TAG, 4'h5};
        15: e = dp(1'b0, 4'hF, 1'b1, 4'h0, 4'h2, 12'h005);
        default: e = dp(1'b0, 4'(k), 1'b1, 4'h2, 4'h2, 12'h005);
      endcase
      xfer({6'b010000, 4'(k), 3'd5, 3'd2}, e, CDEC_F_ALU, b,
        4'h2, 1'b1);
    end
    idle("alu");
  endtask

  task automatic test_hireg;
    xfer(16'h44E1, dp(1'b0, `CDEC_OPC_ADD, 1'b0, 4'h9, 4'h9, 12'h00C), CDEC_F_HIREG,
      4'b0100, 4'h9, 1'b1);
    xfer(16'h4561, dp(1'b0, `CDEC_OPC_CMP, 1'b1, 4'h1, 4'h0, 12'h00C), CDEC_F_HIREG,
      4'b1000, 4'h0, 1'b1);
    xfer(16'h46A1, dp(1'b0, `CDEC_OPC_MOV, 1'b0, 4'h0, 4'h9, 12'h004), CDEC_F_HIREG,
      4'b0100, 4'h9, 1'b1);
    xfer(16'h4760, {`CDEC_COND_AL, `CDEC_BX_STEM, 4'hC}, CDEC_F_HIREG,
      4'b0001, 4'h0, 1'b1);
    xfer(16'h4400, 32'h0000_0000, CDEC_F_HIREG, 4'b0010, 4'h0, 1'b0);
    xfer(16'h47E0, 32'h0000_0000, CDEC_F_HIREG, 4'b0010, 4'h0, 1'b0);
    idle("hireg");
  endtask

  task automatic test_recog;
    cdec_half_t ins [18] = '{16'h4800, 16'h5000, 16'h5200, 16'h6000, 16'h8000, 16'h9000,
      16'hA000, 16'hB000, 16'hB080, 16'hB400, 16'hC000, 16'hD000, 16'hDF00, 16'hE000,
      16'hF000, 16'hF800, 16'hE800, 16'hB100};
    cdec_fmt_e fm [18] = '{CDEC_F_PCLOAD, CDEC_F_LSREG, CDEC_F_LSSIGN, CDEC_F_LSIMM,
      CDEC_F_LSHALF, CDEC_F_SPLS, CDEC_F_LDADDR, CDEC_F_SPADJ, CDEC_F_SPADJ,
      CDEC_F_PUSHPOP, CDEC_F_MULTI, CDEC_F_CONDBR, CDEC_F_TRAP, CDEC_F_BRANCH,
      CDEC_F_LONGBL, CDEC_F_LONGBL, CDEC_F_UNDEF, CDEC_F_UNDEF};
    for (int k = 0; k < 18; k++) begin
      xfer(ins[k], 32'h0000_0000, fm[k], (fm[k] == CDEC_F_UNDEF) ? 4'b0010 : 4'b0000,
        4'h0, 1'b1);
    end
    idle("recognise");
  endtask

  initial begin
    repeat (3) @(posedge clk);
    #1;
    `CHK({out_valid, out_instr, out_fmt}, {33'h0_0000_0000, CDEC_F_UNDEF})
    reset = 1'b0;
    test_shift();
    test_addsub();
    test_imm();
    test_alu();
    test_hireg();
    test_recog();
    @(posedge clk);
    #1;
    `CHK(n_exec, exp_exec)
    `CHK(n_trap, exp_trap)
    results();
  end
endmodule
